/* hdl/ppip_pkg.sv */
// package: register map, field positions and reset values of the pin block
// Functional notes
// - reset leaves pin as power-down input only
// - control bit 0 makes pin interrupt output
// - low pin in input mode forces power-down
// - pin strapped low starts device powered down
// - registers stay reachable; output enable ends pin-forced power-down
// - interrupts off at reset; global enable plus masks
// - pin drives low once enabled condition arises
// - upper flag byte shows every pending source
// - reading flag register clears all pending flags
package ppip_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] BASIC_MODE_IDX    = 8'h00;
  localparam logic [7:0] IRQ_CONTROL_IDX   = 8'h11;
  localparam logic [7:0] IRQ_FLAG_MASK_IDX = 8'h12;
  localparam logic [7:0] EVT_STATUS_IDX    = 8'h20;
  localparam logic [7:0] EVT_ENABLE_IDX    = 8'h21;
  localparam logic [7:0] EVT_CLEAR_IDX     = 8'h22;
  localparam logic [7:0] SLEEP_STATUS_IDX  = 8'h23;

  // field positions
  localparam int BMC_POWER_DOWN_BIT  = 11;
  localparam int IRQ_OUT_ENABLE_BIT  = 0;
  localparam int IRQ_GLOBAL_EN_BIT   = 1;
  localparam int FLAG_LSB            = 8;
  localparam int SRC_COUNT           = 8;
  localparam int EVT_COUNT           = 3;
  localparam int EVT_SLEEP_ENTER_BIT = 0;
  localparam int EVT_SLEEP_EXIT_BIT  = 1;
  localparam int EVT_PIN_IRQ_BIT     = 2;
  localparam int STAT_POWERDOWN_BIT  = 0;
  localparam int STAT_STRAP_LOW_BIT  = 1;
  localparam int STAT_PIN_LEVEL_BIT  = 2;
  localparam int STAT_PIN_DRIVE_BIT  = 3;

  // values after reset
  localparam logic [15:0] BASIC_MODE_RESET  = 16'h0000;
  localparam logic [1:0]  IRQ_CONTROL_RESET = 2'h0;
  localparam logic [7:0]  IRQ_MASK_RESET    = 8'h00;
  localparam logic [2:0]  EVT_ENABLE_RESET  = 3'h0;
  localparam logic [31:0] RDATA_RESET       = 32'h00000000;

endpackage

/* hdl/ppip_sticky.sv */
// sticky flag bank: hardware sets, software clears, set wins
`timescale 1ns/1ns
module ppip_sticky #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // set and clear vectors
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clear,
  // held flags
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } ppip_sticky_state_type;

  ppip_sticky_state_type state;
  ppip_sticky_state_type next_state;

  // a set in the same cycle as its clear survives
  always_comb begin
    next_state      = state;
    next_state.bits = (state.bits & ~clear) | set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.bits;

endmodule

/* hdl/ppip_ahb_port.sv */
// ahb-lite slave front end: phase capture, strobes and registered answer
`timescale 1ns/1ns
module ppip_ahb_port (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave side
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // register file side
  output logic             wr_strobe,
  output logic             rd_strobe,
  output logic      [7:0]  reg_idx,
  output logic             reg_hit,
  input  wire logic [31:0] rd_value
);

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic        hit;
    logic        ready;
    logic [31:0] rdata;
  } ppip_ahb_state_type;

  ppip_ahb_state_type state;
  ppip_ahb_state_type next_state;
  logic               take;

  // reads get one wait state so that a write just before is visible
  always_comb begin
    take            = hsel && htrans[1] && hready;
    next_state      = state;
    next_state.wr   = 1'b0;
    next_state.rd   = 1'b0;
    next_state.ready = 1'b1;
    if (state.rd) begin
      next_state.rdata = state.hit ? rd_value : 32'h00000000;
    end
    if (take) begin
      next_state.wr    = hwrite;
      next_state.rd    = !hwrite;
      next_state.idx   = haddr[9:2];
      next_state.hit   = (haddr[31:10] == 22'h000000) &&
                         (haddr[1:0] == 2'h0);
      next_state.ready = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= '0;
      state.ready <= 1'b1;
      state.rdata <= ppip_pkg::RDATA_RESET;
    end else begin
      state <= next_state;
    end
  end

  // every answer is okay; unmapped words read zero and drop writes
  assign hreadyout = state.ready;
  assign hresp     = 1'b0;
  assign hrdata    = state.rdata;
  assign wr_strobe = state.wr;
  assign rd_strobe = state.rd;
  assign reg_idx   = state.idx;
  assign reg_hit   = state.hit;

endmodule

/* hdl/ppip_top.sv */
// shared power-down / interrupt pin controller with its register file
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module ppip_top (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // ahb-lite register bus
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic      [31:0]                hrdata,
  // interrupt sources of the transceiver core, one-cycle pulses
  input  wire logic [ppip_pkg::SRC_COUNT-1:0] irq_source_event,
  // shared pin, open drain, active low
  input  wire logic                       shared_sleep_irq_pin_in,
  output logic                            shared_sleep_irq_pin_out,
  output logic                            shared_sleep_irq_pin_oe,
  // power-down request to the transceiver core
  output logic                            powerdown,
  // block event interrupt, level
  output logic                            irq
);

  typedef struct packed {
    logic [15:0]                    basic_mode_control_reg;
    logic                           irq_out_enable;
    logic                           irq_global_enable;
    logic [ppip_pkg::SRC_COUNT-1:0] irq_mask;
    logic [ppip_pkg::EVT_COUNT-1:0] evt_enable;
    logic                           strap_taken;
    logic                           strap_low;
    logic                           powerdown;
    logic                           pin_oe;
    logic                           pin_out;
    logic                           irq;
  } ppip_state_type;

  ppip_state_type state;
  ppip_state_type next_state;

  // bus front end outputs
  logic        wr_strobe;
  logic        rd_strobe;
  logic [7:0]  reg_idx;
  logic        reg_hit;
  logic [31:0] rd_value;

  // flag banks
  logic [ppip_pkg::SRC_COUNT-1:0] irq_flags;
  logic [ppip_pkg::SRC_COUNT-1:0] irq_flag_clear;
  logic [ppip_pkg::EVT_COUNT-1:0] evt_status;
  logic [ppip_pkg::EVT_COUNT-1:0] evt_set;
  logic [ppip_pkg::EVT_COUNT-1:0] evt_clear;

  // decoded accesses
  logic wr_basic;
  logic wr_control;
  logic wr_flag_mask;
  logic wr_evt_enable;
  logic wr_evt_clear;
  logic rd_flag_mask;
  logic int_request;
  logic sleep_request;

  ppip_ahb_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_strobe (wr_strobe),
    .rd_strobe (rd_strobe),
    .reg_idx   (reg_idx),
    .reg_hit   (reg_hit),
    .rd_value  (rd_value)
  );

  // pending source flags, upper byte of the flag/mask register
  ppip_sticky #(
    .WIDTH (ppip_pkg::SRC_COUNT)
  ) u_irq_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (irq_source_event),
    .clear   (irq_flag_clear),
    .flags   (irq_flags)
  );

  // block events for the system interrupt line
  ppip_sticky #(
    .WIDTH (ppip_pkg::EVT_COUNT)
  ) u_evt_status (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (evt_set),
    .clear   (evt_clear),
    .flags   (evt_status)
  );

  // access decode; only whole-word transfers are expected
  always_comb begin
    wr_basic      = wr_strobe && reg_hit &&
                    (reg_idx == ppip_pkg::BASIC_MODE_IDX);
    wr_control    = wr_strobe && reg_hit &&
                    (reg_idx == ppip_pkg::IRQ_CONTROL_IDX);
    wr_flag_mask  = wr_strobe && reg_hit &&
                    (reg_idx == ppip_pkg::IRQ_FLAG_MASK_IDX);
    wr_evt_enable = wr_strobe && reg_hit &&
                    (reg_idx == ppip_pkg::EVT_ENABLE_IDX);
    wr_evt_clear  = wr_strobe && reg_hit &&
                    (reg_idx == ppip_pkg::EVT_CLEAR_IDX);
    rd_flag_mask  = rd_strobe && reg_hit &&
                    (reg_idx == ppip_pkg::IRQ_FLAG_MASK_IDX);
  end

  // a read of the flag/mask word clears every pending flag at once;
  // a source pulse in that same cycle stays pending
  assign irq_flag_clear = {ppip_pkg::SRC_COUNT{rd_flag_mask}};
  assign evt_clear      = wr_evt_clear ?
                          hwdata[ppip_pkg::EVT_COUNT-1:0] : '0;

  // pin request: any masked pending flag with global enable set
  always_comb begin
    int_request = state.irq_global_enable &&
                  |(irq_flags & state.irq_mask);
  end

  // power-down from the control bit or from a low pin in input mode;
  // once output mode is chosen the pin level no longer counts
  always_comb begin
    sleep_request =
      state.basic_mode_control_reg[ppip_pkg::BMC_POWER_DOWN_BIT] ||
      (!state.irq_out_enable && !shared_sleep_irq_pin_in);
  end

  // register read multiplexer; reserved bits read zero
  always_comb begin
    rd_value = 32'h00000000;
    unique case (reg_idx)
      ppip_pkg::BASIC_MODE_IDX: begin
        rd_value[15:0] = state.basic_mode_control_reg;
      end
      ppip_pkg::IRQ_CONTROL_IDX: begin
        rd_value[ppip_pkg::IRQ_OUT_ENABLE_BIT] = state.irq_out_enable;
        rd_value[ppip_pkg::IRQ_GLOBAL_EN_BIT]  = state.irq_global_enable;
      end
      ppip_pkg::IRQ_FLAG_MASK_IDX: begin
        rd_value[ppip_pkg::SRC_COUNT-1:0] = state.irq_mask;
        rd_value[ppip_pkg::FLAG_LSB +: ppip_pkg::SRC_COUNT] =
          irq_flags;
      end
      ppip_pkg::EVT_STATUS_IDX: begin
        rd_value[ppip_pkg::EVT_COUNT-1:0] = evt_status;
      end
      ppip_pkg::EVT_ENABLE_IDX: begin
        rd_value[ppip_pkg::EVT_COUNT-1:0] = state.evt_enable;
      end
      ppip_pkg::SLEEP_STATUS_IDX: begin
        rd_value[ppip_pkg::STAT_POWERDOWN_BIT] = state.powerdown;
        rd_value[ppip_pkg::STAT_STRAP_LOW_BIT] = state.strap_low;
        rd_value[ppip_pkg::STAT_PIN_LEVEL_BIT] = shared_sleep_irq_pin_in;
        rd_value[ppip_pkg::STAT_PIN_DRIVE_BIT] = state.pin_oe;
      end
      default: begin
        rd_value = 32'h00000000;
      end
    endcase
  end

  // next state of registers, pin drive and outputs
  always_comb begin
    next_state = state;
    // software writes
    if (wr_basic) begin
      next_state.basic_mode_control_reg = hwdata[15:0];
    end
    if (wr_control) begin
      next_state.irq_out_enable =
        hwdata[ppip_pkg::IRQ_OUT_ENABLE_BIT];
      next_state.irq_global_enable =
        hwdata[ppip_pkg::IRQ_GLOBAL_EN_BIT];
    end
    if (wr_flag_mask) begin
      // only the mask byte is writable, flags are read-only
      next_state.irq_mask = hwdata[ppip_pkg::SRC_COUNT-1:0];
    end
    if (wr_evt_enable) begin
      next_state.evt_enable = hwdata[ppip_pkg::EVT_COUNT-1:0];
    end
    // strap caught on the first edge after reset release
    next_state.strap_taken = 1'b1;
    if (!state.strap_taken) begin
      next_state.strap_low = !shared_sleep_irq_pin_in;
    end
    // a strapped-low pin keeps the device asleep from the start
    next_state.powerdown = sleep_request;
    // open drain: drive low only in output mode with a request,
    // otherwise release so the pull-up or host sets the level
    next_state.pin_oe  = state.irq_out_enable && int_request;
    next_state.pin_out = 1'b0;
    next_state.irq     = |(evt_status & state.evt_enable);
  end

  // block events feeding the system interrupt status bits
  always_comb begin
    evt_set = '0;
    evt_set[ppip_pkg::EVT_SLEEP_ENTER_BIT] =
      next_state.powerdown && !state.powerdown;
    evt_set[ppip_pkg::EVT_SLEEP_EXIT_BIT] =
      !next_state.powerdown && state.powerdown;
    evt_set[ppip_pkg::EVT_PIN_IRQ_BIT] =
      next_state.pin_oe && !state.pin_oe;
  end

  // all control constants at reset: pin is an input, interrupts off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state.basic_mode_control_reg <= ppip_pkg::BASIC_MODE_RESET;
      state.irq_out_enable <=
        ppip_pkg::IRQ_CONTROL_RESET[ppip_pkg::IRQ_OUT_ENABLE_BIT];
      state.irq_global_enable <=
        ppip_pkg::IRQ_CONTROL_RESET[ppip_pkg::IRQ_GLOBAL_EN_BIT];
      state.irq_mask    <= ppip_pkg::IRQ_MASK_RESET;
      state.evt_enable  <= ppip_pkg::EVT_ENABLE_RESET;
      state.strap_taken <= 1'b0;
      state.strap_low   <= 1'b0;
      state.powerdown   <= 1'b0;
      state.pin_oe      <= 1'b0;
      state.pin_out     <= 1'b0;
      state.irq         <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops; the pin follows its
  // request one edge later, a trade for glitch-free drive
  assign shared_sleep_irq_pin_out = state.pin_out;
  assign shared_sleep_irq_pin_oe  = state.pin_oe;
  assign powerdown                = state.powerdown;
  assign irq                      = state.irq;

endmodule

/* tb/ppip_props.sv */
// checker: pin, power-down and bus timing relations of ppip_top
`timescale 1ns/1ns
module ppip_props (
  // clock and reset
  input wire logic                           hclk,
  input wire logic                           hresetn,
  // register bus
  input wire logic                           hsel,
  input wire logic [31:0]                    haddr,
  input wire logic [1:0]                     htrans,
  input wire logic                           hwrite,
  input wire logic [31:0]                    hwdata,
  input wire logic                           hready,
  input wire logic                           hreadyout,
  input wire logic                           hresp,
  // sources, shared pin and outputs
  input wire logic [ppip_pkg::SRC_COUNT-1:0] irq_source_event,
  input wire logic                           shared_sleep_irq_pin_in,
  input wire logic                           shared_sleep_irq_pin_out,
  input wire logic                           shared_sleep_irq_pin_oe,
  input wire logic                           powerdown,
  input wire logic                           irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       ap_wr, ap_rd, sh_oen, sh_gen, sh_bmc, tk, hit, rd_clr, pd_cause;
  logic [7:0] ap_idx, sh_mask;
  // decoded bus request and flag-clearing read phase
  assign tk = hsel && htrans[1] && hready;
  assign hit = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
  assign rd_clr = ap_rd && ap_idx == ppip_pkg::IRQ_FLAG_MASK_IDX && !hready;
  assign pd_cause = sh_bmc || (!sh_oen && !shared_sleep_irq_pin_in);
  // shadow of control bits, snooped so assertions need no internals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ap_wr, ap_rd, ap_idx, sh_oen, sh_gen, sh_bmc, sh_mask} <= '0;
    end else begin
      if (hready) begin
        ap_wr  <= tk && hit && hwrite;
        ap_rd  <= tk && hit && !hwrite;
        ap_idx <= haddr[9:2];
      end
      if (ap_wr && hready && ap_idx == ppip_pkg::BASIC_MODE_IDX) begin
        sh_bmc <= hwdata[ppip_pkg::BMC_POWER_DOWN_BIT];
      end
      if (ap_wr && hready && ap_idx == ppip_pkg::IRQ_CONTROL_IDX) begin
        sh_oen <= hwdata[ppip_pkg::IRQ_OUT_ENABLE_BIT];
        sh_gen <= hwdata[ppip_pkg::IRQ_GLOBAL_EN_BIT];
      end
      if (ap_wr && hready && ap_idx == ppip_pkg::IRQ_FLAG_MASK_IDX) begin
        sh_mask <= hwdata[7:0];
      end
    end
  end
  AST_PD_FOLLOW: assert property ($past(hresetn) |->
    powerdown == $past(pd_cause)) else $error("powerdown wrong");
  AST_RESET_IDLE: assert property ($rose(hresetn) |->
    !shared_sleep_irq_pin_oe && !irq) else $error("pin driven at reset");
  AST_PIN_ASSERT: assert property (
    (|(irq_source_event & sh_mask)) && sh_oen && sh_gen ##1
    (sh_oen && sh_gen && $stable(sh_mask)) |=> shared_sleep_irq_pin_oe)
    else $error("pin not asserted");
  AST_PIN_GATED: assert property (
    !sh_oen || !sh_gen || sh_mask == 8'h00 |=> !shared_sleep_irq_pin_oe)
    else $error("pin asserted while disabled");
  AST_PIN_HOLD: assert property (!rd_clr ##1 (shared_sleep_irq_pin_oe &&
    sh_oen && sh_gen && $stable(sh_mask)) |=> shared_sleep_irq_pin_oe)
    else $error("pin released early");
  AST_READ_CLEARS: assert property (
    rd_clr && irq_source_event == 8'h00 |-> ##2 !shared_sleep_irq_pin_oe)
    else $error("pin stays after flag read");
  AST_READ_WAIT: assert property (tk && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  AST_WRITE_READY: assert property (tk && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_RESP_OKAY: assert property (!hresp)
    else $error("response not okay");
  AST_OPEN_DRAIN: assert property (!shared_sleep_irq_pin_out)
    else $error("pin driven high");
  cover property ($rose(shared_sleep_irq_pin_oe));
  cover property ($rose(powerdown));
  cover property (rd_clr);
endmodule

bind ppip_top ppip_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .irq_source_event,
  .shared_sleep_irq_pin_in, .shared_sleep_irq_pin_out,
  .shared_sleep_irq_pin_oe, .powerdown, .irq);

/* tb/ppip_host.sv */
// host-side model: resolves the shared open-drain pin with its pull-up
`timescale 1ns/1ns
module ppip_host (
  // drivers of the wire
  input  wire logic pin_oe,
  input  wire logic pin_out,
  input  wire logic host_low,
  // resolved level
  output logic      pin_level
);
  // weak pull-up only wins while nobody pulls low
  assign pin_level = !(host_low || (pin_oe && !pin_out));
endmodule

/* tb/test_ppip_top.sv */
// testbench: register table, pin modes and interrupt flow of ppip_top
`timescale 1ns/1ns
module test_ppip_top;
  typedef struct packed {
    logic        wr;
    logic [31:0] a, d, e;
    logic        pd;
  } ppip_row_type;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        host_low = 1'h0, hreadyout, hresp, powerdown, irq;
  logic        shared_sleep_irq_pin_in, shared_sleep_irq_pin_out;
  logic        shared_sleep_irq_pin_oe;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  irq_source_event = 8'h00;
  int          mismatches = 0, n_checks = 0, cycles = 0;
  // reset values first, then write and read back each writable register
  ppip_row_type rows [18] = '{
    '{1'h0, 32'h08C, 32'h0, 32'h4, 1'h0}, '{1'h0, 32'h000, 32'h0, 32'h0, 1'h0},
    '{1'h0, 32'h044, 32'h0, 32'h0, 1'h0}, '{1'h0, 32'h048, 32'h0, 32'h0, 1'h0},
    '{1'h0, 32'h084, 32'h0, 32'h0, 1'h0},
    '{1'h1, 32'h000, 32'h800, 32'h800, 1'h1},
    '{1'h1, 32'h000, 32'hFFFFFFFF, 32'hFFFF, 1'h1},
    '{1'h1, 32'h000, 32'h0, 32'h0, 1'h0},
    '{1'h1, 32'h044, 32'hFFFFFFFF, 32'h3, 1'h0},
    '{1'h1, 32'h044, 32'h0, 32'h0, 1'h0},
    '{1'h1, 32'h048, 32'hFFFFFFFF, 32'hFF, 1'h0},
    '{1'h1, 32'h048, 32'h0, 32'h0, 1'h0},
    '{1'h1, 32'h084, 32'hFFFFFFFF, 32'h7, 1'h0},
    '{1'h1, 32'h084, 32'h0, 32'h0, 1'h0},
    '{1'h1, 32'h088, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h1, 32'h3FC, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h1, 32'h049, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 32'h048, 32'h0, 32'h0, 1'h0}};
  ppip_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .irq_source_event, .shared_sleep_irq_pin_in, .shared_sleep_irq_pin_out,
    .shared_sleep_irq_pin_oe, .powerdown, .irq);
  ppip_host u_host (.pin_oe(shared_sleep_irq_pin_oe),
    .pin_out(shared_sleep_irq_pin_out), .host_low,
    .pin_level(shared_sleep_irq_pin_in));
  always #25 hclk = ~hclk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  // one single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    ahb(1'h1, a, d, rd);
  endtask
  task automatic rdchk(input logic [31:0] a, e);
    ahb(1'h0, a, 32'h0, rd);
    chk("rdata", e, rd);
  endtask
  task automatic pulse(input int i);
    irq_source_event <= 8'h01 << i;
    @(posedge hclk);
    irq_source_event <= 8'h00;
  endtask
  // the watched level is read after the wait, not at the call
  task automatic wait_chk(input string n, input logic e, ref logic g);
    repeat (2) @(posedge hclk);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    chk("pin_oe", 32'h0, {31'h0, shared_sleep_irq_pin_oe});
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
      chk("powerdown", {31'h0, rows[i].pd}, {31'h0, powerdown});
    end
    host_low <= 1'h1;
    wait_chk("powerdown", 1'h1, powerdown);
    host_low <= 1'h0;
    wait_chk("powerdown", 1'h0, powerdown);
    // pin strapped low through a second reset
    host_low <= 1'h1;
    hresetn <= 1'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    wait_chk("powerdown", 1'h1, powerdown);
    rdchk(32'h08C, 32'h3);
    wr(32'h044, 32'h1);
    wait_chk("powerdown", 1'h0, powerdown);
    host_low <= 1'h0;
    wr(32'h084, 32'h4);
    wr(32'h044, 32'h3);
    wr(32'h048, 32'h60);
    pulse(6);
    wait_chk("pin", 1'h0, shared_sleep_irq_pin_in);
    pulse(0);
    wait_chk("pin", 1'h0, shared_sleep_irq_pin_in);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk(32'h048, 32'h4160);
    wait_chk("pin", 1'h1, shared_sleep_irq_pin_in);
    rdchk(32'h048, 32'h60);
    // event interrupt masked, unmasked, then cleared
    wr(32'h084, 32'h0);
    wait_chk("irq", 1'h0, irq);
    wr(32'h084, 32'h4);
    wait_chk("irq", 1'h1, irq);
    wr(32'h088, 32'h4);
    wait_chk("irq", 1'h0, irq);
    // global enable off; low pin ignored in output mode
    wr(32'h044, 32'h1);
    pulse(5);
    host_low <= 1'h1;
    wait_chk("pin_oe", 1'h0, shared_sleep_irq_pin_oe);
    wait_chk("powerdown", 1'h0, powerdown);
    host_low <= 1'h0;
    rdchk(32'h048, 32'h2060);
    tally_and_finish;
  end
endmodule
